// File: src/oar_pkg.sv
// ****************************************************************
// Shared constants of the octal converter readout block
// ****************************************************************
package oar_pkg;

  // Clock rate of the block
  localparam int unsigned CLK_HZ          = 100_000_000;

  // Result layout and channel count
  localparam int unsigned RESULT_BITS     = 12;
  localparam int unsigned CHANNELS        = 8;
  localparam int unsigned DIFF_LANES      = 4;

  // Power-on reinitialisation wait, in ms as printed, and in cycles
  localparam int unsigned POR_WAIT_MS     = 10;
  localparam longint unsigned POR_WAIT_CYC =
    (longint'(POR_WAIT_MS) * longint'(CLK_HZ)) / 64'd1000;

  // Strobe pulses: two enter nap, two more enter sleep, fifth wakes
  localparam logic [2:0] PULSES_TO_NAP    = 3'h2;
  localparam logic [2:0] PULSES_TO_SLEEP  = 3'h4;
  localparam logic [2:0] PULSES_TO_WAKE   = 3'h5;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_STATUS       = 8'h04;
  localparam logic [7:0] REG_RESULT0      = 8'h10;

  // Control register fields and reset value
  localparam int unsigned CTRL_SUPPLY_OK  = 0;
  localparam int unsigned CTRL_TESTPAT    = 1;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

  // Power state of the converter
  typedef enum logic [1:0] {
    PWR_RESET,
    PWR_ACTIVE,
    PWR_NAP,
    PWR_SLEEP
  } oar_pwr_e;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

endpackage

// File: src/oar_sync.sv
`timescale 1ns/1ns
// ****************************************************************
// Two-flop synchroniser with edge detection on the second stage
// ****************************************************************
module oar_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Asynchronous inputs and their synchronised view
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  // Edge detectors look only at the second stage, never the first
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign sync_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
  assign fall_out = ~sync_q & prev_q;

endmodule // oar_sync

// File: src/oar_top.sv
`timescale 1ns/1ns
// Functional notes
// - Reset on power-up or low supply, reinitialise
// - Strobe rise samples, fall starts conversion readout
// - SDR: each shift falling edge shifts next bit
// - DDR: both shift clock edges shift bits
// - Echo clock is delayed, aligned shift clock copy
// - Disable strap keeps echo clock inactive
// - SDR lanes change on echo falling edge
// - Two strobe pulses, static shift clock: nap
// - Nap ends on shift rise or more strobes
// - Two more strobe pulses in nap: sleep
// - Single-ended mode: shift rise exits sleep
// - Fifth strobe pulse exits sleep, clocks prevent reentry
// - Strobes alone cycle active, nap, sleep forever
// - Strap selects eight single or four differential lanes
// - Differential lane pairs carry two channels each
// - Lanes deliver 12-bit results MSB first
// - Lanes output channels circularly from own channel
module oar_top
  import oar_pkg::*;
#(
  parameter longint unsigned POR_CYCLES = POR_WAIT_CYC
) (
  // System clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Converter pins from the receiver
  input  wire logic        conversion_strobe_n,
  input  wire logic        shift_clock,
  input  wire logic        rate_select_pin,
  input  wire logic        diff_mode_pin,
  input  wire logic        echo_disable_pin,
  // Converter pins to the receiver
  output logic             echo_shift_clock,
  output logic [7:0]       single_ended_lanes,
  output logic [3:0]       differential_lane_pairs,
  // Sampled channel values from the analog core
  input  wire logic [95:0] sample_data,
  output logic             sample_take,
  output logic             core_powered,
  output logic             ready_for_conv,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [4:0] pin_sync;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  oar_sync #(.W(5)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({echo_disable_pin, diff_mode_pin, rate_select_pin,
                shift_clock, conversion_strobe_n}),
    .sync_out (pin_sync),
    .rise_out (pin_rise),
    .fall_out (pin_fall)
  );

  logic cnv_rise;
  logic cnv_fall;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  logic ddr_mode;
  logic diff_mode;
  logic echo_off;

  assign cnv_rise  = pin_rise[0];
  assign cnv_fall  = pin_fall[0];
  assign sck_lvl   = pin_sync[1];
  assign sck_rise  = pin_rise[1];
  assign sck_fall  = pin_fall[1];
  assign ddr_mode  = pin_sync[2];
  assign diff_mode = pin_sync[3];
  assign echo_off  = pin_sync[4];

  // Channel word picker, used by the result register read
  function automatic logic [RESULT_BITS-1:0] chan_word(
    input logic [95:0] data, input logic [2:0] ch);
    chan_word = data[ch*RESULT_BITS +: RESULT_BITS];
  endfunction

  // Single result bit picker, so no select lands on a call result
  function automatic logic chan_bit(
    input logic [95:0] data, input logic [2:0] ch, input logic [3:0] pos);
    chan_bit = data[ch*RESULT_BITS + pos];
  endfunction

  // ****************************************************************
  // Register file state
  // ****************************************************************
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic        supply_ok;
  assign supply_ok = ctrl_q[CTRL_SUPPLY_OK];

  // ****************************************************************
  // Power state, reinitialisation and strobe pulse counting
  // ****************************************************************
  oar_pwr_e        pwr_q;
  oar_pwr_e        pwr_d;
  logic [2:0]      pulses_q;
  logic [2:0]      pulses_d;
  logic            clk_seen_q;
  logic            clk_seen_d;
  logic [23:0]     por_cnt_q;
  logic [23:0]     por_cnt_d;

  // Supply loss forces reset; counter models the reinitialisation
  always_comb begin
    pwr_d      = pwr_q;
    pulses_d   = pulses_q;
    clk_seen_d = clk_seen_q | sck_rise | sck_fall;
    por_cnt_d  = por_cnt_q;
    if (!supply_ok) begin
      pwr_d     = PWR_RESET;
      por_cnt_d = '0;
      pulses_d  = '0;
    end else begin
      case (pwr_q)
        PWR_RESET: begin
          if (por_cnt_q >= 24'(POR_CYCLES - 1)) begin
            pwr_d = PWR_ACTIVE;
          end else begin
            por_cnt_d = por_cnt_q + 24'h1;
          end
        end
        PWR_ACTIVE: begin
          if (cnv_rise) begin
            // Any shift clock edge since the last strobe restarts the count
            pulses_d   = clk_seen_q ? 3'h1 : pulses_q + 3'h1;
            // A shift edge in this very cycle still counts for the next strobe
            clk_seen_d = sck_rise | sck_fall;
            if (!clk_seen_q && pulses_q + 3'h1 == PULSES_TO_NAP) begin
              pwr_d = PWR_NAP;
            end
          end
        end
        PWR_NAP: begin
          if (sck_rise) begin
            pwr_d    = PWR_ACTIVE;
            pulses_d = '0;
          end else if (cnv_rise) begin
            pulses_d = pulses_q + 3'h1;
            if (pulses_q + 3'h1 == PULSES_TO_SLEEP) begin
              pwr_d = PWR_SLEEP;
            end
          end
        end
        PWR_SLEEP: begin
          if (sck_rise && !diff_mode) begin
            pwr_d    = PWR_ACTIVE;
            pulses_d = '0;
          end else if (cnv_rise) begin
            // Strobes alone keep cycling through the states
            pwr_d      = PWR_ACTIVE;
            pulses_d   = '0;
            clk_seen_d = sck_rise | sck_fall;
          end
        end
        default: pwr_d = PWR_RESET;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q      <= PWR_RESET;
      pulses_q   <= '0;
      clk_seen_q <= 1'b0;
      por_cnt_q  <= '0;
    end else begin
      pwr_q      <= pwr_d;
      pulses_q   <= pulses_d;
      clk_seen_q <= clk_seen_d;
      por_cnt_q  <= por_cnt_d;
    end
  end

  assign core_powered   = (pwr_q == PWR_ACTIVE);
  assign ready_for_conv = (pwr_q != PWR_RESET);

  // ****************************************************************
  // Sampling, conversion and serial shifting
  // ****************************************************************
  logic [95:0] held_q;
  logic [95:0] held_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic [2:0]  slot_q;
  logic [2:0]  slot_d;
  logic [7:0]  se_q;
  logic [7:0]  se_d;
  logic [3:0]  df_q;
  logic [3:0]  df_d;
  logic        echo_q;
  logic        echo_d;
  logic        take;
  logic        shift;

  // Rising strobe samples the core; only in full-power operation
  assign take  = cnv_fall && pwr_q == PWR_ACTIVE;
  assign shift = ddr_mode ? (sck_rise | sck_fall) : sck_fall;
  assign sample_take = cnv_rise && pwr_q == PWR_ACTIVE;

  // Lanes and echo clock advance together so they stay aligned
  always_comb begin
    logic [2:0]  ch;
    logic [3:0]  pos;
    logic [95:0] src;
    ch     = '0;
    pos    = '0;
    src    = ctrl_q[CTRL_TESTPAT] ? {8{12'ha5c}} : sample_data;
    held_d = held_q;
    bit_d  = bit_q;
    slot_d = slot_q;
    se_d   = se_q;
    df_d   = df_q;
    echo_d = echo_off ? 1'b0 : sck_lvl;
    if (take) begin
      held_d = src;
      bit_d  = 4'h0;
      slot_d = 3'h0;
      // First MSB appears at the strobe fall
      for (int l = 0; l < CHANNELS; l++) begin
        se_d[l] = chan_bit(src, 3'(l), 4'(RESULT_BITS - 1));
      end
      for (int l = 0; l < DIFF_LANES; l++) begin
        df_d[l] = chan_bit(src, 3'(2 * l), 4'(RESULT_BITS - 1));
      end
    end else if (shift && pwr_q == PWR_ACTIVE) begin
      if (bit_q == 4'(RESULT_BITS - 1)) begin
        bit_d  = 4'h0;
        slot_d = slot_q + 3'h1;
      end else begin
        bit_d = bit_q + 4'h1;
      end
      pos = 4'(RESULT_BITS - 1) - bit_d;
      for (int l = 0; l < CHANNELS; l++) begin
        ch      = 3'(l) + slot_d;
        se_d[l] = chan_bit(held_q, ch, pos);
      end
      for (int l = 0; l < DIFF_LANES; l++) begin
        ch      = 3'(2 * l) + slot_d;
        df_d[l] = chan_bit(held_q, ch, pos);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_q <= '0;
      bit_q  <= '0;
      slot_q <= '0;
      se_q   <= '0;
      df_q   <= '0;
      echo_q <= 1'b0;
    end else begin
      held_q <= held_d;
      bit_q  <= bit_d;
      slot_q <= slot_d;
      se_q   <= se_d;
      df_q   <= df_d;
      echo_q <= echo_d;
    end
  end

  // Strap picks which lane set drives; the other stays low
  assign single_ended_lanes      = diff_mode ? 8'h00 : se_q;
  assign differential_lane_pairs = diff_mode ? df_q : 4'h0;
  assign echo_shift_clock        = echo_q;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        ws_q, ws_d;

  // Address and data are taken in either order; reply after both
  always_comb begin
    aw_d   = aw_q;
    w_d    = w_q;
    b_d    = b_q;
    r_d    = r_q;
    awa_d  = awa_q;
    wd_d   = wd_q;
    ws_d   = ws_q;
    rd_d   = rd_q;
    br_d   = br_q;
    rr_d   = rr_q;
    ctrl_d = ctrl_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      // Strobe is kept with the data; the master may drop it once taken
      ws_d = s_axi_wstrb[0];
    end
    if (aw_q && w_q && !b_q) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = RESP_SLVERR;
      if (awa_q == REG_CTRL) begin
        br_d = RESP_OKAY;
        if (ws_q) begin
          ctrl_d[7:0] = wd_q[7:0];
        end
      end
    end
    if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_d  = 1'b1;
      rr_d = RESP_OKAY;
      rd_d = 32'h0;
      case (s_axi_araddr)
        REG_CTRL:   rd_d = ctrl_q;
        REG_STATUS: rd_d = {24'h0, diff_mode, ddr_mode, echo_off,
                            pulses_q, 2'(pwr_q)};
        default: begin
          if (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[4] && s_axi_araddr[1:0] == 2'h0) begin
            rd_d = {20'h0, chan_word(held_q, {1'b0, s_axi_araddr[3:2]})};
          end else begin
            rr_d = RESP_SLVERR;
          end
        end
      endcase
    end
    if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q   <= 1'b0;
      w_q    <= 1'b0;
      b_q    <= 1'b0;
      r_q    <= 1'b0;
      awa_q  <= '0;
      wd_q   <= '0;
      ws_q   <= 1'b0;
      rd_q   <= '0;
      br_q   <= RESP_OKAY;
      rr_q   <= RESP_OKAY;
      ctrl_q <= CTRL_RESET;
    end else begin
      aw_q   <= aw_d;
      w_q    <= w_d;
      b_q    <= b_d;
      r_q    <= r_d;
      awa_q  <= awa_d;
      wd_q   <= wd_d;
      ws_q   <= ws_d;
      rd_q   <= rd_d;
      br_q   <= br_d;
      rr_q   <= rr_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready  = !w_q && !b_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

endmodule // oar_top

// File: test/oar_chk_sva.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checker of the converter readout block
// ****************************************************************
module oar_chk #(
  parameter longint unsigned POR_CYCLES = 20
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Link pins and straps
  input wire logic        conversion_strobe_n,
  input wire logic        shift_clock,
  input wire logic        rate_select_pin,
  input wire logic        diff_mode_pin,
  input wire logic        echo_disable_pin,
  input wire logic        echo_shift_clock,
  input wire logic [7:0]  single_ended_lanes,
  input wire logic [3:0]  differential_lane_pairs,
  // Core side and read data channel
  input wire logic        sample_take,
  input wire logic        core_powered,
  input wire logic        ready_for_conv,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // Slack around the wait covers the synchroniser stages
  localparam int POR_LO = int'(POR_CYCLES) - 2;
  localparam int POR_HI = int'(POR_CYCLES) + 4;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // One rising shift clock edge as sampled by aclk
  sequence s_shift_rise;
    !shift_clock ##1 shift_clock;
  endsequence

  // Parked in single-ended nap or sleep after initialisation
  sequence s_parked;
    !core_powered && ready_for_conv && !diff_mode_pin;
  endsequence

  AST_POR_HOLD:
    assert property ($rose(aresetn) |-> (!ready_for_conv && !core_powered) [*8])
    else $error("core powered too early after reset");
  AST_POR_DONE:
    assert property ($rose(aresetn) |-> ##[POR_LO:POR_HI] ready_for_conv)
    else $error("reinitialisation not over in time");
  AST_TAKE:
    assert property (sample_take |->
      core_powered && $past(conversion_strobe_n) && !$past(conversion_strobe_n, 4))
    else $error("sampling start without strobe rise");
  AST_LANE_EDGE:
    assert property (!rate_select_pin && $changed({differential_lane_pairs,
      single_ended_lanes}) |-> !$past(shift_clock, 2))
    else $error("lanes moved after a rising shift edge");
  AST_ECHO_COPY:
    assert property ($past(aresetn, 3) && !echo_disable_pin && !$past(echo_disable_pin, 3)
      |-> echo_shift_clock == $past(shift_clock, 3))
    else $error("echo clock is not the delayed shift clock");
  AST_ECHO_OFF:
    assert property (echo_disable_pin [*4] |-> !echo_shift_clock)
    else $error("echo clock active while disabled");
  AST_SE_QUIET:
    assert property (diff_mode_pin [*3] |-> single_ended_lanes == 8'h00)
    else $error("single-ended lanes driven in differential mode");
  AST_DIFF_QUIET:
    assert property (!diff_mode_pin [*3] |-> differential_lane_pairs == 4'h0)
    else $error("differential lanes driven in single-ended mode");
  AST_WAKE:
    assert property (s_parked ##0 s_shift_rise |-> ##[1:6] core_powered)
    else $error("shift rise did not wake the core");
  AST_READ_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule // oar_chk

bind oar_top oar_chk #(.POR_CYCLES(POR_CYCLES)) u_oar_chk (
  .aclk, .aresetn, .conversion_strobe_n, .shift_clock, .rate_select_pin, .diff_mode_pin,
  .echo_disable_pin, .echo_shift_clock, .single_ended_lanes, .differential_lane_pairs,
  .sample_take, .core_powered, .ready_for_conv, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// File: test/oar_rx_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Receiver model: drives strobe and shift clock, captures lanes
// ****************************************************************
module oar_rx_model (
  // Lanes and rate strap seen by the receiver
  input wire logic [7:0] single_ended_lanes,
  input wire logic [3:0] differential_lane_pairs,
  input wire logic       rate_select_pin,
  // Pins driven toward the converter
  output logic           conversion_strobe_n,
  output logic           shift_clock
);
  logic [11:0] lanes_all;
  logic [31:0] cap [12];

  // Differential lanes sit above the eight single-ended ones
  assign lanes_all = {differential_lane_pairs, single_ended_lanes};

  // Shift clock stands still outside frames
  initial begin
    conversion_strobe_n = 1'b0;
    shift_clock         = 1'b0;
  end

  // Strobe pulse; two with no shift edge between park the core
  task automatic strobe_pulse();
    #7 conversion_strobe_n = 1'b1;
    #30 conversion_strobe_n = 1'b0;
    #100;
  endtask

  // Toggle the shift clock at 125 ns, sampling before each shifting edge;
  // the rate is scaled down so the block clock can see every level
  task automatic shift_edges(input int n);
    for (int l = 0; l < 12; l++) cap[l] = '0;
    for (int e = 0; e < n; e++) begin
      #(62 + e % 2);
      if (rate_select_pin || shift_clock) begin
        for (int l = 0; l < 12; l++) cap[l] = {cap[l][30:0], lanes_all[l]};
      end
      shift_clock = ~shift_clock;
    end
    #60;
  endtask
endmodule // oar_rx_model

// File: test/tb_top.sv
`timescale 1ns/1ns
// ****************************************************************
// Testbench of the converter readout block
// ****************************************************************
module tb_top;
  import oar_pkg::*;
  localparam longint unsigned POR_SIM = 20;
  localparam logic [95:0]     SAMPLES = 96'h8ff7ee6dd5cc4bb3aa299188;
  logic        aclk, aresetn, conversion_strobe_n, shift_clock;
  logic        rate_select_pin, diff_mode_pin, echo_disable_pin, echo_shift_clock;
  logic [7:0]  single_ended_lanes, s_axi_awaddr, s_axi_araddr;
  logic [3:0]  differential_lane_pairs, s_axi_wstrb;
  logic [95:0] sample_data;
  logic        sample_take, core_powered, ready_for_conv;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          bad_count, tests_run, cycles;

  oar_top #(.POR_CYCLES(POR_SIM)) dut (
    .aclk, .aresetn, .conversion_strobe_n, .shift_clock, .rate_select_pin, .diff_mode_pin,
    .echo_disable_pin, .echo_shift_clock, .single_ended_lanes, .differential_lane_pairs,
    .sample_data, .sample_take, .core_powered, .ready_for_conv, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  oar_rx_model rx (
    .single_ended_lanes, .differential_lane_pairs, .rate_select_pin,
    .conversion_strobe_n, .shift_clock);

  // 100 MHz system clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Hang guard, well above the some 1350 cycles the run needs
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Ready and response are read at the falling edge, so the rising edge sees the same
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ha, hw, got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ha, got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  // One frame of 128/lanes bits per lane: own channel first, then circular
  task automatic conv(input bit diff, input bit ddr);
    int          c;
    int          nb;
    logic [35:0] w;
    nb = diff ? 32 : 16;
    rx.strobe_pulse();
    rx.shift_edges(ddr ? nb : 2 * nb);
    for (int l = 0; l < (diff ? 4 : 8); l++) begin
      c = diff ? 2 * l : l;
      w = {SAMPLES[c*12 +: 12], SAMPLES[((c + 1) % 8)*12 +: 12],
           SAMPLES[((c + 2) % 8)*12 +: 12]};
      check(32'(rx.cap[diff ? l + 8 : l]), 32'(w >> (36 - nb)),
        "lane word");
    end
    $display("Frame test done, diff %0d ddr %0d", diff, ddr);
  endtask

  task automatic state_is(input oar_pwr_e s);
    axi_rd(REG_STATUS, d, r);
    check(32'(d[1:0]), 32'(s), "power state");
    check(32'(d[7:6]), 32'({diff_mode_pin, rate_select_pin}), "strap status");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {aresetn, rate_select_pin, diff_mode_pin, echo_disable_pin} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    sample_data = SAMPLES;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check(32'({ready_for_conv, core_powered}), 32'h0, "early ready");
    axi_rd(REG_CTRL, d, r);
    check(d, CTRL_RESET, "control reset value");
    axi_rd(8'h40, d, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped read response");
    check(d, 32'h0, "unmapped read data");
    axi_wr(8'h40, 32'h0000_00ff, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped write");
    repeat (30) @(negedge aclk);
    check(32'({ready_for_conv, core_powered}), 32'h3, "ready after wait");
    $display("Reset and register test done");
    conv(1'b0, 1'b0);
    conv(1'b0, 1'b0);
    axi_rd(REG_RESULT0, d, r);
    check(d, 32'(SAMPLES[11:0]), "held result");
    @(posedge aclk) rate_select_pin <= 1'b1;
    conv(1'b0, 1'b1);
    @(posedge aclk) {rate_select_pin, diff_mode_pin, echo_disable_pin} <= 3'h3;
    conv(1'b1, 1'b0);
    @(posedge aclk) {diff_mode_pin, echo_disable_pin} <= 2'h0;
    repeat (2) rx.strobe_pulse();
    state_is(PWR_NAP);
    rx.shift_edges(2);
    state_is(PWR_ACTIVE);
    repeat (4) rx.strobe_pulse();
    state_is(PWR_SLEEP);
    rx.shift_edges(2);
    state_is(PWR_ACTIVE);
    @(posedge aclk) diff_mode_pin <= 1'b1;
    repeat (4) rx.strobe_pulse();
    state_is(PWR_SLEEP);
    rx.strobe_pulse();
    state_is(PWR_ACTIVE);
    // No result is relied on right after a sleep exit
    repeat (2) rx.strobe_pulse();
    state_is(PWR_NAP);
    $display("Power state test done");
    rx.shift_edges(2);
    axi_wr(REG_CTRL, 32'h0000_0003, r);
    rx.strobe_pulse();
    axi_rd(REG_RESULT0, d, r);
    check(d, 32'h0000_0a5c, "test pattern result");
    axi_wr(REG_CTRL, 32'h0, r);
    @(negedge aclk);
    check(32'({ready_for_conv, core_powered}), 32'h0, "supply loss");
    axi_wr(REG_CTRL, CTRL_RESET, r);
    repeat (30) @(negedge aclk);
    check(32'(ready_for_conv), 32'h1, "reinitialised");
    $display("Supply loss test done");
    wrap_up();
  end
endmodule // tb_top
